// file: shared/c2bru_pkg.sv
package c2bru_pkg;
	// machine word and instruction layout
	localparam int GPR_W       = 64;
	localparam int INSTR_W     = 32;
	localparam int IMM_W       = 16;
	localparam int CC_W        = 3;
	localparam int NCOND       = 8;
	localparam int OFS_SHIFT   = 2;
	// field positions of the coprocessor branch word
	localparam int OPC_HI      = 31;
	localparam int OPC_LO      = 26;
	localparam int SUB_HI      = 25;
	localparam int SUB_LO      = 21;
	localparam int CC_HI       = 20;
	localparam int CC_LO       = 18;
	localparam int ND_BIT      = 17;
	localparam int TF_BIT      = 16;
	localparam logic [5:0] OPC_COP2 = 6'h12;
	localparam logic [4:0] SUB_BC   = 5'h08;
	// arbitrary value for the held addresses out of reset; nothing fetches from it
	localparam logic [GPR_W-1:0] PC_RESET = 64'h0000000000000000;

	// branch outcome recorded at the branch, applied in the delay slot
	typedef enum logic [1:0] {
		C2BRU_IDLE,
		C2BRU_SLOT
	} c2bru_state_e;

	// exception codes reported instead of completing the branch
	typedef enum logic [1:0] {
		C2BRU_EXC_NONE,
		C2BRU_EXC_CPU,
		C2BRU_EXC_RI
	} c2bru_exc_e;
endpackage

// file: core/c2bru_decode.sv
`timescale 1ns/1ps
// one generic conditional branch: true/false select and nullify flag
module c2bru_decode
	import c2bru_pkg::*;
(
	input  wire logic [INSTR_W-1:0] instr,
	input  wire logic [NCOND-1:0]   coproc2_condition_bit,
	input  wire logic [GPR_W-1:0]   slot_pc,
	output logic                    is_branch,
	output logic                    true_false_select,
	output logic                    nullify_delay_slot_flag,
	output logic                    cond_met,
	output logic [GPR_W-1:0]        target
);
	logic [CC_W-1:0] condition_select_field;
	logic [GPR_W-1:0] target_offset;

	// variant pair comes straight out of the encoding
	assign is_branch = (instr[OPC_HI:OPC_LO] == OPC_COP2) && (instr[SUB_HI:SUB_LO] == SUB_BC);
	assign true_false_select       = instr[TF_BIT];
	assign nullify_delay_slot_flag = instr[ND_BIT];
	// short form encodes zero, which picks bit zero here
	assign condition_select_field = instr[CC_HI:CC_LO];
	assign cond_met = (coproc2_condition_bit[condition_select_field] == true_false_select);
	// sign-extended word offset added to the delay-slot address
	assign target_offset = {{(GPR_W-IMM_W-OFS_SHIFT){instr[IMM_W-1]}}, instr[IMM_W-1:0],
		{OFS_SHIFT{1'b0}}};
	assign target = slot_pc + target_offset;
endmodule

// file: core/c2bru_unit.sv
`timescale 1ns/1ps
// Functional notes
// - target = delay-slot address plus sign-extended immediate shifted left two.
// - false forms branch when selected coprocessor condition bit is zero.
// - true forms branch when selected coprocessor condition bit is one.
// - likely forms nullify the delay-slot instruction when not taken.
// - evaluate at the branch; redirect or nullify in the cycle after the delay-slot instruction issues.
// - omitted selector encodes zero, testing condition bit zero.
// - all four decode as one branch with true/false and nullify bits.
// - report coprocessor-unusable or reserved-instruction instead of branching.
module c2bru_unit
	import c2bru_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               issue_valid,
	input  wire logic [INSTR_W-1:0] issue_instr,
	input  wire logic [GPR_W-1:0]   issue_pc,
	input  wire logic               cop2_usable,
	input  wire logic               cop2_present,
	input  wire logic [NCOND-1:0]   coproc2_condition_bit,
	output logic                    pc_redirect,
	output logic [GPR_W-1:0]        redirect_pc,
	output logic                    squash_delay_instruction,
	output logic                    exc_valid,
	output c2bru_exc_e              exc_code,
	output logic [GPR_W-1:0]        exc_pc
);
	c2bru_state_e     state;
	logic             is_branch;
	logic             tf_sel;
	logic             nd_flag;
	logic             cond_met;
	logic [GPR_W-1:0] target;
	logic [GPR_W-1:0] slot_pc;
	logic             take;
	logic             kill;
	logic             fault;
	logic             pend_take;
	logic             pend_kill;
	logic [GPR_W-1:0] pend_target;
	logic             slot_now;

	// delay slot follows the branch word
	assign slot_pc = issue_pc + GPR_W'(INSTR_W / 8);

	// condition bit picked by the selector field of an instruction word
	function automatic logic sel_cond(
		input logic [NCOND-1:0]   bits,
		input logic [INSTR_W-1:0] word
	);
		return bits[word[CC_HI:CC_LO]];
	endfunction

	// the delay-slot instruction executes this cycle; a gap before it just waits
	assign slot_now = (state == C2BRU_SLOT) && issue_valid;

	c2bru_decode u_decode (
		.instr                   (issue_instr),
		.coproc2_condition_bit   (coproc2_condition_bit),
		.slot_pc                 (slot_pc),
		.is_branch               (is_branch),
		.true_false_select       (tf_sel),
		.nullify_delay_slot_flag (nd_flag),
		.cond_met                (cond_met),
		.target                  (target)
	);

	// a faulting branch must not redirect or squash anything
	assign fault = issue_valid && is_branch && (!cop2_present || !cop2_usable);
	assign take  = issue_valid && is_branch && !fault && cond_met;
	// only the likely forms squash; ordinary forms always run the slot
	assign kill  = issue_valid && is_branch && !fault && !cond_met && nd_flag;

	// decision captured at the branch, held for the delay slot
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state       <= C2BRU_IDLE;
			pend_take   <= 1'b0;
			pend_kill   <= 1'b0;
			pend_target <= PC_RESET;
		end else begin
			case (state)
				C2BRU_IDLE: begin
					if (take || kill) begin
						state       <= C2BRU_SLOT;
						pend_take   <= take;
						pend_kill   <= kill;
						pend_target <= target;
					end
				end
				C2BRU_SLOT: begin
					// waits for the delay-slot word; software keeps it a plain one
					if (issue_valid) begin
						state     <= C2BRU_IDLE;
						pend_take <= 1'b0;
						pend_kill <= 1'b0;
					end
				end
				default: begin
					state <= C2BRU_IDLE;
				end
			endcase
		end
	end

	// redirect and squash are registered, landing one cycle after the delay-slot instruction issues
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_redirect              <= 1'b0;
			redirect_pc              <= PC_RESET;
			squash_delay_instruction <= 1'b0;
		end else begin
			pc_redirect              <= slot_now && pend_take;
			squash_delay_instruction <= slot_now && pend_kill;
			if (slot_now && pend_take) begin
				redirect_pc <= pend_target;
			end
		end
	end

	// a missing coprocessor reads as reserved, a present but disabled one as unusable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			exc_valid <= 1'b0;
			exc_code  <= C2BRU_EXC_NONE;
			exc_pc    <= PC_RESET;
		end else begin
			exc_valid <= fault;
			if (fault) begin
				exc_code <= cop2_present ? C2BRU_EXC_CPU : C2BRU_EXC_RI;
				exc_pc   <= issue_pc;
			end else begin
				exc_code <= C2BRU_EXC_NONE;
			end
		end
	end

	property p_redirect_after_take;
		@(posedge clk) disable iff (!rst_b)
		take ##1 issue_valid |=> pc_redirect && !squash_delay_instruction;
	endproperty
	a_redirect_after_take: assert property (p_redirect_after_take)
		else $error("taken branch did not redirect with its delay slot");

	property p_target_value;
		@(posedge clk) disable iff (!rst_b)
		take ##1 issue_valid |=> redirect_pc == $past(target, 2);
	endproperty
	a_target_value: assert property (p_target_value)
		else $error("redirect address differs from computed target");

	property p_false_form;
		@(posedge clk) disable iff (!rst_b)
		(issue_valid && is_branch && !fault && !tf_sel
			&& !sel_cond(coproc2_condition_bit, issue_instr)) |-> take;
	endproperty
	a_false_form: assert property (p_false_form)
		else $error("false form not taken on clear bit");

	property p_true_form;
		@(posedge clk) disable iff (!rst_b)
		(issue_valid && is_branch && !fault && tf_sel) |->
			(take == sel_cond(coproc2_condition_bit, issue_instr));
	endproperty
	a_true_form: assert property (p_true_form)
		else $error("true form outcome wrong");

	property p_likely_squash;
		@(posedge clk) disable iff (!rst_b)
		(issue_valid && is_branch && !fault && nd_flag && !cond_met) ##1 issue_valid
			|=> squash_delay_instruction && !pc_redirect;
	endproperty
	a_likely_squash: assert property (p_likely_squash)
		else $error("likely not-taken did not squash delay slot");

	property p_plain_no_squash;
		@(posedge clk) disable iff (!rst_b)
		(issue_valid && is_branch && !nd_flag) ##1 1'b1 |=> !squash_delay_instruction;
	endproperty
	a_plain_no_squash: assert property (p_plain_no_squash)
		else $error("ordinary branch squashed its delay slot");

	property p_cc_zero;
		@(posedge clk) disable iff (!rst_b)
		(issue_valid && is_branch && !fault && issue_instr[CC_HI:CC_LO] == '0)
			|-> cond_met == (coproc2_condition_bit[0] == tf_sel);
	endproperty
	a_cc_zero: assert property (p_cc_zero)
		else $error("zero selector did not test bit zero");

	property p_exc_blocks;
		@(posedge clk) disable iff (!rst_b)
		fault |=> exc_valid && exc_code != C2BRU_EXC_NONE && $stable(state) ##1 !pc_redirect;
	endproperty
	a_exc_blocks: assert property (p_exc_blocks)
		else $error("faulting branch not reported or still redirected");

	property p_decode_pair;
		@(posedge clk) disable iff (!rst_b)
		issue_valid && is_branch |-> tf_sel == issue_instr[TF_BIT]
			&& nd_flag == issue_instr[ND_BIT]
			&& (fault || (take == (sel_cond(coproc2_condition_bit, issue_instr)
				== issue_instr[TF_BIT]) && kill == (issue_instr[ND_BIT] && !take)));
	endproperty
	a_decode_pair: assert property (p_decode_pair)
		else $error("variant decoded to wrong select pair");

	property p_pulse_single;
		@(posedge clk) disable iff (!rst_b)
		pc_redirect || squash_delay_instruction |=> !pc_redirect && !squash_delay_instruction;
	endproperty
	a_pulse_single: assert property (p_pulse_single)
		else $error("redirect or squash held past one cycle");

	property p_wait_for_slot;
		@(posedge clk) disable iff (!rst_b)
		!slot_now |=> !pc_redirect && !squash_delay_instruction;
	endproperty
	a_wait_for_slot: assert property (p_wait_for_slot)
		else $error("redirect or squash before the delay slot executed");

	property p_exc_only_on_fault;
		@(posedge clk) disable iff (!rst_b)
		!fault |=> !exc_valid && exc_code == C2BRU_EXC_NONE;
	endproperty
	a_exc_only_on_fault: assert property (p_exc_only_on_fault)
		else $error("exception reported without a faulting branch");

	property p_exc_kind;
		@(posedge clk) disable iff (!rst_b)
		fault |=> exc_pc == $past(issue_pc) && (exc_code == C2BRU_EXC_RI) == !$past(cop2_present);
	endproperty
	a_exc_kind: assert property (p_exc_kind)
		else $error("exception address or kind wrong");
endmodule

// file: bench/c2bru_cop2_model.sv
`timescale 1ns/1ps
// coprocessor 2 side: holds the condition bits its compare ops produce
module c2bru_cop2_model
	import c2bru_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             set_valid,
	input  wire logic [NCOND-1:0] set_bits,
	output logic      [NCOND-1:0] coproc2_condition_bit
);
	// bits move only when a compare retires, so a branch never sees them mid-change
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coproc2_condition_bit <= '0;
		end else if (set_valid) begin
			coproc2_condition_bit <= set_bits;
		end
	end
endmodule

// file: bench/c2bru_unit_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module c2bru_unit_tb;
	import c2bru_pkg::*;
	logic             clk, rst_b, issue_valid, cop2_usable, cop2_present, set_valid;
	logic [31:0]      issue_instr;
	logic [63:0]      issue_pc, redirect_pc, exc_pc;
	logic [NCOND-1:0] set_bits, cond;
	logic             pc_redirect, squash_delay_instruction, exc_valid;
	c2bru_exc_e       exc_code;
	// reference outcomes {redirect, squash, target} queued at the branch
	logic [65:0]      want_q[$];
	int               errors = 0;
	int               check_count = 0;

	// free-running core clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	c2bru_cop2_model i_c2bru_cop2_model (.clk(clk), .rst_b(rst_b), .set_valid(set_valid),
		.set_bits(set_bits), .coproc2_condition_bit(cond));
	c2bru_unit i_c2bru_unit (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
		.issue_instr(issue_instr), .issue_pc(issue_pc), .cop2_usable(cop2_usable),
		.cop2_present(cop2_present), .coproc2_condition_bit(cond), .pc_redirect(pc_redirect),
		.redirect_pc(redirect_pc), .squash_delay_instruction(squash_delay_instruction),
		.exc_valid(exc_valid), .exc_code(exc_code), .exc_pc(exc_pc));

	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// inputs move 1 ns after the edge so sampling never races
	task tick;
		@(posedge clk);
		#1;
	endtask

	// one branch plus its delay slot, checked against a reference computed here
	task run_br(input logic tf, nd, input logic [2:0] cc, input logic [15:0] off,
		input logic [7:0] bits, input logic use_ok, pres, input int gap);
		logic [63:0] pc, tgt;
		logic        fault, taken;
		logic [65:0] want;
		pc = {$urandom, $urandom} & ~64'h3;
		set_valid = 1;
		set_bits = bits;
		tick;
		set_valid = 0;
		tick;
		fault = !pres || !use_ok;
		taken = bits[cc] == tf;
		tgt = pc + 64'h4 + {{46{off[15]}}, off, 2'b00};
		want_q.push_back({!fault && taken, !fault && !taken && nd, tgt});
		cop2_usable = use_ok;
		cop2_present = pres;
		issue_valid = 1;
		issue_pc = pc;
		issue_instr = {OPC_COP2, SUB_BC, cc, nd, tf, off};
		tick;
		`CHK("exc_valid", fault, exc_valid)
		if (fault) `CHK("exc_code", pres ? C2BRU_EXC_CPU : C2BRU_EXC_RI, exc_code)
		if (fault) `CHK("exc_pc", pc, exc_pc)
		// slot holds a plain op, never another control transfer
		issue_instr = 32'h0;
		issue_pc = pc + 64'h4;
		// slot may lag the branch; valid is set once per step, never dropped and raised
		issue_valid = gap == 0;
		for (int g = 1; g <= gap; g++) begin
			tick;
			`CHK("early", 1'b0, pc_redirect | squash_delay_instruction)
			issue_valid = g == gap;
		end
		tick;
		issue_valid = 0;
		want = want_q.pop_front();
		`CHK("pc_redirect", want[65], pc_redirect)
		`CHK("squash", want[64], squash_delay_instruction)
		if (want[65]) `CHK("redirect_pc", want[63:0], redirect_pc)
		tick;
		`CHK("pulse_len", 1'b0, pc_redirect | squash_delay_instruction)
	endtask

	// hang guard, far beyond the roughly 1450 cycles at most that the run needs
	initial begin
		#100000;
		errors++;
		$display("[ERR] watchdog expired");
		tally_and_finish;
	end

	initial begin
		{issue_valid, set_valid, rst_b} = 3'h0;
		{cop2_usable, cop2_present} = 2'h3;
		issue_instr = '0;
		issue_pc = '0;
		set_bits = '0;
		void'($urandom(32'h84ce7b79));
		repeat (5) @(posedge clk);
		#1 rst_b = 1;
		`CHK("redirect_pc_rst", PC_RESET, redirect_pc)
		`CHK("exc_code_rst", C2BRU_EXC_NONE, exc_code)
		`CHK("pulses_rst", 1'b0, pc_redirect | squash_delay_instruction | exc_valid)
		// every variant with the selector left at zero, offsets at both extremes
		for (int v = 0; v < 4; v++) begin
			run_br(v[0], v[1], 3'h0, v[0] ? 16'h8000 : 16'h7fff, 8'hfe, 1, 1, 0);
		end
		run_br(1, 0, 3'h2, 16'h0010, 8'hff, 1, 0, 0);
		run_br(0, 1, 3'h5, 16'h0010, 8'h00, 0, 1, 1);
		for (int i = 0; i < 200; i++) begin
			// likely forms drawn a quarter of the time: software prefers the ordinary ones
			run_br(1'($urandom), $urandom % 4 == 0, 3'($urandom), 16'($urandom), 8'($urandom),
				$urandom % 8 != 0, $urandom % 8 != 0, $urandom % 3);
		end
		tally_and_finish;
	end
endmodule
